//--- hw/lcd_pkg.sv
// package: constants, types and helpers shared by both ends of the display link
package lcd_pkg;
// Functional notes
// - width bit picks eight lines or nibble pairs
// - setup first; later setups need width change
// - pattern address loads six bits into counter
// - text address loads seven bits into counter
// - text addresses wrap per one/two line layout
// - busy readback; instructions refused while busy
// - host polls busy clear before next write
// - busy readback also returns address counter
// - cursor shift steps counter down or up
// - display shift left or right, cursor follows
// - shift decoded from data_bit4 as top bit
// - lines and font bits select duty
// - data write stores, steps, maybe shifts display
// - data read returns prefetched byte of selected RAM
// - data read steps counter, never shifts display
// - cursor shift reloads read data like address set
// - read after write returns stale data
// - entry direction picks increment or decrement
// - entry shift moves display opposite cursor
// - counter steps a fixed delay after busy clears
   localparam int CLK_NS = 50;
   localparam int EXEC_NS = 37000;
   localparam int ADD_NS = 4000;
   localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADD_CYC = (ADD_NS + CLK_NS - 1) / CLK_NS;
   localparam int E_HIGH_CYC = 2;
   localparam int TEXT_DEPTH = 128;
   localparam int PAT_DEPTH = 64;
   localparam logic [3:0] BIT_TEXT = 4'h7;
   localparam logic [3:0] BIT_PAT = 4'h6;
   localparam logic [3:0] BIT_FUNC = 4'h5;
   localparam logic [3:0] BIT_SHIFT = 4'h4;
   localparam logic [3:0] BIT_DISP = 4'h3;
   localparam logic [3:0] BIT_ENTRY = 4'h2;
   localparam int FS_WIDTH = 4;
   localparam int FS_LINES = 3;
   localparam int FS_FONT = 2;
   localparam int SH_TARGET = 3;
   localparam int SH_DIR = 2;
   localparam int EM_DIR = 1;
   localparam int EM_SHIFT = 0;
   localparam int DC_DISP = 2;
   localparam int DC_CUR = 1;
   localparam int DC_BLINK = 0;
   localparam int BUSY_BIT = 7;
   localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
   localparam logic [6:0] LINE1_LAST = 7'h27;
   localparam logic [6:0] LINE2_FIRST = 7'h40;
   localparam logic [6:0] LINE2_LAST = 7'h67;
   localparam logic WIDTH8_RST = 1'b1;
   localparam logic ENTRY_INC_RST = 1'b1;
   localparam logic POLL_EN_RST = 1'b1;
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam int CMD_RS = 8;
   localparam int CMD_RW = 9;
   typedef enum logic [1:0] {DUTY_8 = 2'b00, DUTY_11 = 2'b01, DUTY_16 = 2'b10} duty_type;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_SETUP = 2'b01, H_STROBE = 2'b10, H_GAP = 2'b11} host_state_type;

   // index of highest set bit, 4'hF for an all-zero byte
   function automatic logic [3:0] top_bit(input logic [7:0] b);
      logic [3:0] r;
      r = 4'hF;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
         begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // one step of the address counter inside the valid windows
   function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic two, input logic pat);
      logic [6:0] r;
      r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      if (pat)
      begin
         r = {1'b0, r[5:0]};
      end
      else if (!two)
      begin
         if (up && a == ONE_LINE_LAST)
         begin
            r = 7'h00;
         end
         else if (!up && a == 7'h00)
         begin
            r = ONE_LINE_LAST;
         end
      end
      else if (up)
      begin
         if (a == LINE1_LAST)
         begin
            r = LINE2_FIRST;
         end
         else if (a == LINE2_LAST)
         begin
            r = 7'h00;
         end
      end
      else if (a == LINE2_FIRST)
      begin
         r = LINE1_LAST;
      end
      else if (a == 7'h00)
      begin
         r = LINE2_LAST;
      end
      return r;
   endfunction
endpackage

//--- hw/lcd_link_if.sv
// interface: parallel strobe link between the host end and the display end
`timescale 1ns/1ns
interface lcd_link_if;
   logic e;
   logic reg_select;
   logic rw;
   logic [7:0] h_db;
   logic h_oe;
   logic [7:0] d_db;
   logic d_oe;
   logic [7:0] db;
   // resolved bus level; undriven lines read high
   assign db = d_oe ? d_db : (h_oe ? h_db : 8'hFF);
   modport dev (input e, input reg_select, input rw, input db, output d_db, output d_oe);
   modport host (output e, output reg_select, output rw, output h_db, output h_oe, input db);
endinterface

//--- hw/lcd_nibble_pair.sv
// module: pairs two upper-nibble transfers into one byte in narrow mode
`timescale 1ns/1ns
module lcd_nibble_pair
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_strobe,
   input wire logic i_width8,
   input wire logic [7:0] i_db,
   output logic o_done,
   output logic [7:0] o_byte,
   output logic o_low_next
);
   logic low_q;
   logic [3:0] hi_q;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         low_q <= 1'b0;
         hi_q <= 4'h0;
      end
      else if (i_width8)
      begin
         low_q <= 1'b0;
      end
      else if (i_strobe)
      begin
         low_q <= ~low_q;
         if (!low_q)
         begin
            hi_q <= i_db[7:4];
         end
      end
   end

   assign o_done = i_strobe & (i_width8 | low_q);
   assign o_byte = i_width8 ? i_db : {hi_q, i_db[7:4]};
   assign o_low_next = low_q;
endmodule

//--- hw/lcd_dev_end.sv
// module: display end, decodes and executes instructions from the link
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module lcd_dev_end
#(
   parameter int EXEC_CYCLES = lcd_pkg::EXEC_CYC,
   parameter int ADD_CYCLES = lcd_pkg::ADD_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   lcd_link_if.dev link,
   input wire logic [6:0] i_scan_addr,
   output logic [7:0] o_scan_char,
   output logic o_width8,
   output logic o_lines2,
   output logic o_font10,
   output lcd_pkg::duty_type o_duty,
   output logic [6:0] o_disp_ofs,
   output logic o_display_on,
   output logic o_cursor_on,
   output logic o_blink_on
);
   import lcd_pkg::*;

   logic e_q;
   logic strobe;
   logic byte_done;
   logic low_next;
   logic [7:0] in_byte;
   logic width8_q;
   logic lines2_q;
   logic font10_q;
   logic setup_done_q;
   logic inc_q;
   logic ent_shift_q;
   logic disp_on_q;
   logic cur_on_q;
   logic blink_q;
   logic pat_sel_q;
   logic [6:0] ac_q;
   logic [6:0] ofs_q;
   logic [7:0] latch_q;
   logic [7:0] rd_q;
   logic [7:0] scan_q;
   logic [$clog2(EXEC_CYCLES + 1)-1:0] busy_cnt_q;
   logic [$clog2(ADD_CYCLES + 1)-1:0] add_cnt_q;
   logic add_pend_q;
   logic add_fetch_q;
   logic busy_ind;
   logic go;
   logic add_done;
   logic [6:0] ac_now;
   logic [6:0] shift_addr;
   logic [3:0] top;
   logic [7:0] data_now;
   logic [7:0] shown;
   logic [7:0] text_mem [TEXT_DEPTH];
   logic [7:0] pattern_mem [PAT_DEPTH];

   function automatic logic [7:0] mem_rd(input logic [6:0] a, input logic pat);
      return pat ? pattern_mem[a[5:0]] : text_mem[a];
   endfunction

   // display offset moves within the line length of the current layout
   function automatic logic [6:0] shift_ofs(input logic [6:0] o, input logic right, input logic two);
      logic [6:0] last;
      last = two ? LINE1_LAST : ONE_LINE_LAST;
      if (right)
      begin
         return (o == 7'h00) ? last : 7'(o - 7'h01);
      end
      return (o == last) ? 7'h00 : 7'(o + 7'h01);
   endfunction

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         e_q <= 1'b0;
      end
      else
      begin
         e_q <= link.e;
      end
   end

   assign strobe = link.e & ~e_q;

   lcd_nibble_pair lcd_nibble_pair_i
   (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_strobe(strobe),
      .i_width8(width8_q),
      .i_db(link.db),
      .o_done(byte_done),
      .o_byte(in_byte),
      .o_low_next(low_next)
   );

   assign busy_ind = busy_cnt_q != '0;
   // busy readback is always answered, everything else is dropped while busy
   assign go = byte_done & ~busy_ind & ~(~link.reg_select & link.rw);
   assign add_done = add_pend_q & ~busy_ind & (add_cnt_q == 1);
   // a pending step is folded in when a new access overtakes it
   assign ac_now = add_pend_q ? step_addr(ac_q, inc_q, lines2_q, pat_sel_q) : ac_q;
   assign shift_addr = step_addr(ac_now, in_byte[SH_DIR], lines2_q, pat_sel_q);
   assign top = top_bit(in_byte);
   assign data_now = (add_pend_q & add_fetch_q) ? mem_rd(ac_now, pat_sel_q) : latch_q;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy_cnt_q <= '0;
         add_cnt_q <= '0;
      end
      else
      begin
         if (go)
         begin
            busy_cnt_q <= ($clog2(EXEC_CYCLES + 1))'(EXEC_CYCLES);
         end
         else if (busy_ind)
         begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
         end
         if (busy_cnt_q == 1 && add_pend_q)
         begin
            add_cnt_q <= ($clog2(ADD_CYCLES + 1))'(ADD_CYCLES);
         end
         else if (add_cnt_q != '0)
         begin
            add_cnt_q <= add_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         width8_q <= WIDTH8_RST;
         lines2_q <= 1'b0;
         font10_q <= 1'b0;
         setup_done_q <= 1'b0;
         inc_q <= ENTRY_INC_RST;
         ent_shift_q <= 1'b0;
         disp_on_q <= 1'b0;
         cur_on_q <= 1'b0;
         blink_q <= 1'b0;
         pat_sel_q <= 1'b0;
         ac_q <= 7'h00;
         ofs_q <= 7'h00;
         latch_q <= 8'h00;
         add_pend_q <= 1'b0;
         add_fetch_q <= 1'b0;
      end
      else if (go)
      begin
         add_pend_q <= 1'b0;
         add_fetch_q <= 1'b0;
         ac_q <= ac_now;
         if (link.reg_select && link.rw)
         begin
            latch_q <= data_now;
            add_pend_q <= 1'b1;
            add_fetch_q <= 1'b1;
         end
         else if (link.reg_select)
         begin
            add_pend_q <= 1'b1;
            if (ent_shift_q && !pat_sel_q)
            begin
               ofs_q <= shift_ofs(ofs_q, ~inc_q, lines2_q);
            end
         end
         else
         begin
            case (top)
               BIT_TEXT:
               begin
                  ac_q <= in_byte[6:0];
                  pat_sel_q <= 1'b0;
                  latch_q <= text_mem[in_byte[6:0]];
               end
               BIT_PAT:
               begin
                  ac_q <= {1'b0, in_byte[5:0]};
                  pat_sel_q <= 1'b1;
                  latch_q <= pattern_mem[in_byte[5:0]];
               end
               BIT_FUNC:
               begin
                  if (!setup_done_q || in_byte[FS_WIDTH] != width8_q)
                  begin
                     width8_q <= in_byte[FS_WIDTH];
                     lines2_q <= in_byte[FS_LINES];
                     font10_q <= in_byte[FS_FONT];
                  end
                  setup_done_q <= 1'b1;
               end
               BIT_SHIFT:
               begin
                  if (in_byte[SH_TARGET])
                  begin
                     ofs_q <= shift_ofs(ofs_q, in_byte[SH_DIR], lines2_q);
                  end
                  else
                  begin
                     ac_q <= shift_addr;
                     latch_q <= mem_rd(shift_addr, pat_sel_q);
                  end
               end
               BIT_DISP:
               begin
                  disp_on_q <= in_byte[DC_DISP];
                  cur_on_q <= in_byte[DC_CUR];
                  blink_q <= in_byte[DC_BLINK];
               end
               BIT_ENTRY:
               begin
                  inc_q <= in_byte[EM_DIR];
                  ent_shift_q <= in_byte[EM_SHIFT];
               end
               default:
               begin
                  ac_q <= ac_now;
               end
            endcase
         end
      end
      else if (add_done)
      begin
         ac_q <= ac_now;
         add_pend_q <= 1'b0;
         add_fetch_q <= 1'b0;
         if (add_fetch_q)
         begin
            latch_q <= mem_rd(ac_now, pat_sel_q);
         end
      end
   end

   // write-only path leaves the read latch untouched, so the next read is stale
   always_ff @(posedge i_mclk)
   begin
      if (go && link.reg_select && !link.rw)
      begin
         if (pat_sel_q)
         begin
            pattern_mem[ac_now[5:0]] <= in_byte;
         end
         else
         begin
            text_mem[ac_now] <= in_byte;
         end
      end
   end

   assign shown = link.reg_select ? data_now : {busy_ind, ac_q};

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd_q <= 8'h00;
         scan_q <= 8'h00;
      end
      else
      begin
         rd_q <= width8_q ? shown : (low_next ? {shown[3:0], 4'h0} : {shown[7:4], 4'h0});
         scan_q <= text_mem[i_scan_addr];
      end
   end

   assign link.d_db = rd_q;
   assign link.d_oe = link.e & link.rw;
   assign o_scan_char = scan_q;
   assign o_width8 = width8_q;
   assign o_lines2 = lines2_q;
   assign o_font10 = font10_q & ~lines2_q;
   assign o_duty = lines2_q ? DUTY_16 : (font10_q ? DUTY_11 : DUTY_8);
   assign o_disp_ofs = ofs_q;
   assign o_display_on = disp_on_q;
   assign o_cursor_on = cur_on_q;
   assign o_blink_on = blink_q;
endmodule

//--- hw/lcd_host_end.sv
// module: host end, APB registers driving byte transfers on the display link
`timescale 1ns/1ns
module lcd_host_end
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   lcd_link_if.host link
);
   import lcd_pkg::*;

   host_state_type state_q;
   logic [1:0] cnt_q;
   logic low_q;
   logic polling_q;
   logic width8_q;
   logic poll_en_q;
   logic refused_q;
   logic [9:0] cmd_q;
   logic [7:0] rx_q;
   logic [31:0] prdata_q;
   logic wr_cmd;
   logic last_nib;
   logic [7:0] out_byte;
   logic mapped;

   assign mapped = (i_paddr == CMD_OFS) || (i_paddr == CTRL_OFS) || (i_paddr == STAT_OFS);
   assign wr_cmd = i_psel & i_penable & i_pwrite & (i_paddr == CMD_OFS);
   assign last_nib = width8_q | low_q;
   assign out_byte = polling_q ? 8'h00 : cmd_q[7:0];

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         poll_en_q <= POLL_EN_RST;
         refused_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         if (i_psel && i_penable && i_pwrite && i_paddr == CTRL_OFS)
         begin
            poll_en_q <= i_pwdata[0];
         end
         if (wr_cmd)
         begin
            refused_q <= state_q != H_IDLE;
         end
         if (i_psel && !i_penable)
         begin
            if (i_paddr == CTRL_OFS)
            begin
               prdata_q <= {31'h0, poll_en_q};
            end
            else if (i_paddr == STAT_OFS)
            begin
               prdata_q <= {16'h0, rx_q, 5'h0, refused_q, width8_q, state_q != H_IDLE};
            end
            else
            begin
               prdata_q <= 32'h0;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= H_IDLE;
         cnt_q <= 2'd0;
         low_q <= 1'b0;
         polling_q <= 1'b0;
         width8_q <= WIDTH8_RST;
         cmd_q <= 10'h0;
         rx_q <= 8'h00;
      end
      else
      begin
         case (state_q)
            H_IDLE:
            begin
               if (wr_cmd)
               begin
                  cmd_q <= i_pwdata[9:0];
                  // poll busy clear first unless the order is itself a busy read
                  polling_q <= poll_en_q & (i_pwdata[CMD_RS] | ~i_pwdata[CMD_RW]);
                  low_q <= 1'b0;
                  state_q <= H_SETUP;
               end
            end
            H_SETUP:
            begin
               cnt_q <= 2'(E_HIGH_CYC - 1);
               state_q <= H_STROBE;
            end
            H_STROBE:
            begin
               if (cnt_q != 2'd0)
               begin
                  cnt_q <= cnt_q - 2'd1;
               end
               else
               begin
                  if (width8_q)
                  begin
                     rx_q <= link.db;
                  end
                  else if (!low_q)
                  begin
                     rx_q[7:4] <= link.db[7:4];
                  end
                  else
                  begin
                     rx_q[3:0] <= link.db[7:4];
                  end
                  state_q <= H_GAP;
               end
            end
            default:
            begin
               low_q <= ~last_nib;
               state_q <= H_SETUP;
               if (last_nib && polling_q)
               begin
                  polling_q <= rx_q[BUSY_BIT];
               end
               else if (last_nib)
               begin
                  state_q <= H_IDLE;
                  if (!cmd_q[CMD_RS] && !cmd_q[CMD_RW] && top_bit(cmd_q[7:0]) == BIT_FUNC)
                  begin
                     width8_q <= cmd_q[FS_WIDTH];
                  end
               end
            end
         endcase
      end
   end

   assign link.e = state_q == H_STROBE;
   assign link.reg_select = polling_q ? 1'b0 : cmd_q[CMD_RS];
   assign link.rw = polling_q ? 1'b1 : cmd_q[CMD_RW];
   assign link.h_db = (width8_q || low_q) && !(!width8_q && !low_q) ?
      (width8_q ? out_byte : {out_byte[3:0], 4'h0}) : {out_byte[7:4], 4'h0};
   assign link.h_oe = (state_q != H_IDLE) & ~link.rw;
   assign o_prdata = prdata_q;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;
endmodule

//--- tb/lcd_link_props.sv
// checker: timing and drive rules of the parallel link between the two ends
`timescale 1ns/1ns
module lcd_link_props
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic e,
   input wire logic reg_select,
   input wire logic rw,
   input wire logic [7:0] h_db,
   input wire logic h_oe,
   input wire logic [7:0] d_db,
   input wire logic d_oe,
   input wire logic [7:0] db
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_read_drive: assert property (e && rw |-> d_oe)
      else $error("device silent during read strobe");
   a_drive_only_read: assert property (d_oe |-> e && rw)
      else $error("device drives outside read strobe");
   a_no_clash: assert property (!(d_oe && h_oe))
      else $error("both ends drive the bus");
   a_strobe_len: assert property ($rose(e) |=> e ##1 !e)
      else $error("strobe not two cycles");
   a_gap_setup: assert property ($fell(e) |-> !e ##1 !e)
      else $error("strobe gap too short");
   a_ctrl_stable: assert property ($past(e) |-> $stable(reg_select) && $stable(rw))
      else $error("select or direction moved in strobe");
   a_wdata_held: assert property ($past(e) && !rw |-> $stable(h_db))
      else $error("write data moved in strobe");
   a_write_drive: assert property (e && !rw |-> h_oe)
      else $error("host not driving write data");
   a_bus_level: assert property (d_oe |-> db == d_db)
      else $error("bus level differs from device drive");

   c_data_read: cover property ($rose(e) && rw && reg_select);
   c_data_write: cover property ($rose(e) && !rw && reg_select);
   c_instr: cover property ($rose(e) && !rw && !reg_select);
endmodule

//--- tb/lcd_instruction_decoder_tb_top.sv
// testbench: APB host end driving the display end over the link
`timescale 1ns/1ns
module lcd_instruction_decoder_tb_top;
   import lcd_pkg::*;
   localparam int EXC = 40;
   localparam int ADC = 3;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, slv;
   logic [7:0] paddr, scan_char;
   logic [31:0] pwdata, prdata, q;
   logic [6:0] scan_addr, disp_ofs;
   logic width8, lines2, font10, display_on, cursor_on, blink_on;
   duty_type duty;
   int mismatches, checks_done;
   lcd_link_if link();
   lcd_host_end lcd_host_end_i (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .link(link.host));
   lcd_dev_end #(.EXEC_CYCLES(EXC), .ADD_CYCLES(ADC)) lcd_dev_end_i (.i_mclk(mclk), .i_rst_n(rst_n),
      .link(link.dev), .i_scan_addr(scan_addr), .o_scan_char(scan_char), .o_width8(width8),
      .o_lines2(lines2), .o_font10(font10), .o_duty(duty), .o_disp_ofs(disp_ofs),
      .o_display_on(display_on), .o_cursor_on(cursor_on), .o_blink_on(blink_on));
   lcd_link_props lcd_link_props_i (.i_mclk(mclk), .i_rst_n(rst_n), .e(link.e), .reg_select(link.reg_select),
      .rw(link.rw), .h_db(link.h_db), .h_oe(link.h_oe), .d_db(link.d_db), .d_oe(link.d_oe), .db(link.db));

   task automatic results;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic hang;
      mismatches++;
      $display("BAD %0t wait limit reached", $time);
      results();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         hang();
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one link command, then wait until the host engine is idle
   task automatic go(input logic rs, input logic rw, input logic [7:0] b);
      int n;
      apb(1'b1, CMD_OFS, {22'h000000, rw, rs, b});
      n = 0;
      do
      begin
         apb(1'b0, STAT_OFS, 32'h00000000);
         n++;
      end
      while (q[0] !== 1'b0 && n < 100);
      if (q[0] !== 1'b0)
         hang();
   endtask

   // command, then let busy and the delayed address step run out
   task automatic cmd(input logic rs, input logic rw, input logic [7:0] b);
      go(rs, rw, b);
      repeat (EXC + ADC + 4) @(posedge mclk);
      apb(1'b0, STAT_OFS, 32'h00000000);
   endtask

   task automatic st(input logic [7:0] exp);
      cmd(1'b0, 1'b1, 8'h00);
      chk(q[15:8], exp, "busy and counter");
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      scan_addr = 7'h27;
      mismatches = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chk(width8, 1, "reset width");
      chk(duty, DUTY_8, "reset duty");
      apb(1'b0, 8'hF0, 32'h00000000);
      chk(q, 32'h00000000, "unmapped data");
      chk(slv, 1, "unmapped error");
      apb(1'b0, CTRL_OFS, 32'h00000000);
      chk(q[0], 1, "poll enable");
      cmd(1'b0, 1'b0, 8'h38);
      chk({lines2, duty}, {1'b1, DUTY_16}, "two lines");
      cmd(1'b0, 1'b0, 8'h34);
      chk({lines2, duty}, {1'b1, DUTY_16}, "repeat setup");
      cmd(1'b0, 1'b0, 8'h0F);
      chk({display_on, cursor_on, blink_on}, 3'h7, "display control");
      cmd(1'b0, 1'b0, 8'h06);
      cmd(1'b0, 1'b0, 8'hA7);
      st(8'h27);
      cmd(1'b1, 1'b0, 8'h55);
      chk(scan_char, 8'h55, "text store");
      st(8'h40);
      cmd(1'b0, 1'b0, 8'hA7);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'h55, "text read");
      st(8'h40);
      cmd(1'b0, 1'b0, 8'h10);
      st(8'h27);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'h55, "read after cursor");
      cmd(1'b0, 1'b0, 8'h17);
      st(8'h41);
      cmd(1'b0, 1'b0, 8'h18);
      chk(disp_ofs, 7'h01, "shift left");
      st(8'h41);
      cmd(1'b0, 1'b0, 8'h1C);
      chk(disp_ofs, 7'h00, "shift right");
      cmd(1'b0, 1'b0, 8'h05);
      cmd(1'b1, 1'b0, 8'h66);
      chk(disp_ofs, 7'h27, "entry shift");
      st(8'h40);
      cmd(1'b0, 1'b0, 8'h07);
      cmd(1'b0, 1'b0, 8'h7F);
      st(8'h3F);
      cmd(1'b1, 1'b0, 8'hA5);
      chk(disp_ofs, 7'h27, "pattern no shift");
      st(8'h00);
      cmd(1'b0, 1'b0, 8'h7F);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'hA5, "pattern read");
      cmd(1'b0, 1'b0, 8'h7F);
      cmd(1'b1, 1'b0, 8'h11);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'hA5, "stale after write");
      cmd(1'b0, 1'b0, 8'h7F);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'h11, "pattern rewrite");
      cmd(1'b0, 1'b0, 8'hA7);
      cmd(1'b1, 1'b1, 8'h00);
      chk({disp_ofs, q[15:8]}, {7'h27, 8'h55}, "read no shift");
      st(8'h40);
      apb(1'b1, CMD_OFS, 32'h00000018);
      cmd(1'b0, 1'b0, 8'h18);
      chk({q[2], disp_ofs}, {1'b1, 7'h00}, "host refusal");
      apb(1'b1, CTRL_OFS, 32'h00000000);
      go(1'b0, 1'b0, 8'h18);
      go(1'b0, 1'b0, 8'h18);
      cmd(1'b0, 1'b1, 8'h00);
      chk({q[15], disp_ofs}, {1'b1, 7'h01}, "device refusal");
      apb(1'b1, CTRL_OFS, 32'h00000001);
      cmd(1'b0, 1'b0, 8'h24);
      chk({width8, font10, duty, q[1]}, {2'b01, DUTY_11, 1'b0}, "nibble setup");
      scan_addr <= 7'h45;
      cmd(1'b0, 1'b0, 8'hC5);
      cmd(1'b1, 1'b0, 8'h3C);
      chk(scan_char, 8'h3C, "nibble store");
      st(8'h46);
      cmd(1'b0, 1'b0, 8'hC5);
      cmd(1'b1, 1'b1, 8'h00);
      chk(q[15:8], 8'h3C, "nibble read");
      cmd(1'b0, 1'b0, 8'hCF);
      cmd(1'b1, 1'b0, 8'h77);
      st(8'h00);
      cmd(1'b0, 1'b0, 8'h30);
      chk({width8, duty, q[1]}, {1'b1, DUTY_8, 1'b1}, "wide again");
      results();
   end
endmodule
